// ===== rtl/rfmb_cfg.svh
// Constants of the multi-block read and activity pin logic.
`ifndef RFMB_CFG_SVH
`define RFMB_CFG_SVH
`define RFMB_CMD_READ_MULTI 8'h23
`define RFMB_ERR_NONE 8'h00
`define RFMB_ERR_UNSPEC 8'h0f
`define RFMB_ERR_NO_BLOCK 8'h10
`define RFMB_ERR_RD_PROT 8'h15
`define RFMB_RESP_OK 8'h00
`define RFMB_RESP_ERR 8'h01
`define RFMB_FLAG_ADDR 5
`define RFMB_FLAG_OPT 6
`define RFMB_IDX_FLAGS 4'h0
`define RFMB_IDX_CMD 4'h1
`define RFMB_IDX_UID 4'h2
`define RFMB_IDX_FIRST_SEL 4'h2
`define RFMB_IDX_FIRST_ADDR 4'ha
`define RFMB_IDX_MAX 4'hf
`define RFMB_LAST_BYTE 2'h3
`define RFMB_NUM_BLOCKS 512
`define RFMB_SECTOR_BLOCKS 32
`define RFMB_CRC_INIT 16'hffff
`define RFMB_CRC_POLY 16'h8408
`define RFMB_REG_CTRL 12'h000
`define RFMB_REG_STATUS 12'h004
`define RFMB_REG_MASK 12'h008
`define RFMB_REG_INFO 12'h00c
`define RFMB_CTRL_WIP_BIT 0
`define RFMB_EV_W 3
`define RFMB_EV_RD_OK 0
`define RFMB_EV_RD_ERR 1
`define RFMB_EV_IGNORED 2
`endif

// ===== rtl/rfmb_pkg.sv
// Types shared by the multi-block read and activity pin logic.
package rfmb_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RX = 4'b0010,
        ST_SKIP = 4'b0100,
        ST_TX = 4'b1000
    } rfmb_state_type;
    typedef enum logic [6:0] {
        PH_FLAGS = 7'b0000001,
        PH_CODE = 7'b0000010,
        PH_SEC = 7'b0000100,
        PH_DATA = 7'b0001000,
        PH_NEXT = 7'b0010000,
        PH_CRCL = 7'b0100000,
        PH_CRCH = 7'b1000000
    } rfmb_phase_type;
endpackage

// ===== rtl/rfmb_if.sv
// Interfaces between the reader core, its CRC engine and pin control.
interface rfmb_crc_if;
    logic clr;
    logic en;
    logic [7:0] data;
    logic [15:0] crc;
    modport user (output clr, en, data, input crc);
    modport engine (input clr, en, data, output crc);
endinterface

interface rfmb_pin_if;
    logic wip_mode;
    logic rx_sof;
    logic rx_eof;
    logic rx_ok;
    logic resp_sof;
    logic resp_eof;
    logic release_now;
    logic wr_accept;
    logic wr_option;
    logic drive;
    modport ctl (output wip_mode, rx_sof, rx_eof, rx_ok, resp_sof,
        resp_eof, release_now, wr_accept, wr_option, input drive);
    modport pin (input wip_mode, rx_sof, rx_eof, rx_ok, resp_sof,
        resp_eof, release_now, wr_accept, wr_option, output drive);
endinterface

// ===== rtl/rfmb_crc.sv
// Response CRC16 engine, reflected polynomial, fed one byte at a time.
`include "rfmb_cfg.svh"
module rfmb_crc (
    input wire logic clk,
    input wire logic sys_rst,
    rfmb_crc_if.engine bus
);
    import rfmb_pkg::*;

    typedef struct packed {
        logic [15:0] crc;
    } rfmb_crc_state_type;

    rfmb_crc_state_type s_q, s_d;

    // Shifts one byte through the register, low bit first.
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `RFMB_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // A clear restarts the sum and may be combined with the first byte.
    always_comb begin
        s_d = s_q;
        if (bus.clr) begin
            s_d.crc = `RFMB_CRC_INIT;
        end
        if (bus.en) begin
            s_d.crc = crc_step(s_d.crc, bus.data);
        end
    end

    // Registers the running sum.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q.crc <= `RFMB_CRC_INIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.crc = s_q.crc;
endmodule

// ===== rtl/rfmb_pin.sv
// Activity pin control for busy indication and write progress modes.
module rfmb_pin (
    input wire logic clk,
    input wire logic sys_rst,
    rfmb_pin_if.pin bus
);
    import rfmb_pkg::*;

    typedef struct packed {
        logic busy;
        logic wip;
        logic wip_to_end;
        logic drive;
    } rfmb_pin_state_type;

    rfmb_pin_state_type s_q, s_d;

    // Releases come first so a frame start in the same cycle wins.
    always_comb begin
        s_d = s_q;
        if (bus.resp_eof || bus.release_now || (bus.rx_eof && !bus.rx_ok)) begin
            s_d.busy = 1'b0;
        end
        if (bus.rx_sof) begin
            s_d.busy = 1'b1;
        end
        if ((bus.resp_sof && !s_q.wip_to_end) || bus.resp_eof) begin
            s_d.wip = 1'b0;
            s_d.wip_to_end = 1'b0;
        end
        // Refused writes raise no accept strobe, so the write flag stays clear.
        if (bus.wr_accept) begin
            s_d.wip = 1'b1;
            s_d.wip_to_end = bus.wr_option;
        end
        // Reads never set the write flag.
        s_d.drive = bus.wip_mode ? s_d.wip : s_d.busy;
    end

    // Registers the pin state.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.drive = s_q.drive;
endmodule

// ===== rtl/rfmb_top.sv
// Multi-block read handler with activity pin and APB registers.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`include "rfmb_cfg.svh"
// How it works
// - Busy mode: pin low from write start to reply end.
// - Progress mode: pin low from valid write end to reply start.
// - Progress mode: refused write leaves the pin released.
// - Busy mode: refused write drives pin until exchange ends.
// - Option-flag write: pin released only after the late reply.
// - Count field is blocks minus one.
// - Block numbers span 00h to 1FFh; the request carries the first block number in one byte, 00h to FFh.
// - Up to 32 blocks returned when all lie in one sector.
// - A range crossing a sector boundary gets an error reply.
// - Reply: flags, per block optional security byte and word, CRC.
// - Security byte: top three bits zero, low five from the sector.
// - Error reply carries code 0Fh, 10h or 15h and CRC.
// - Busy mode: pin low from read start to reply end.
// - Progress mode: pin released for the whole read.
module rfmb_top #(
    parameter int NUM_BLOCKS = `RFMB_NUM_BLOCKS,
    parameter int SECTOR_BLOCKS = `RFMB_SECTOR_BLOCKS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic rx_sof,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_eof,
    input wire logic rx_crc_ok,
    input wire logic [63:0] own_uid,
    output logic [8:0] mem_addr,
    input wire logic [31:0] mem_rdata,
    input wire logic [7:0] sec_status,
    input wire logic sec_read_denied,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic resp_sof,
    input wire logic resp_eof,
    input wire logic resp_none,
    input wire logic wr_accept,
    input wire logic wr_option,
    input wire logic rf_activity_pin_i,
    output logic rf_activity_pin_o,
    output logic rf_activity_pin_oe
);
    import rfmb_pkg::*;

    typedef struct packed {
        rfmb_state_type st;
        rfmb_phase_type ph;
        logic [3:0] idx;
        logic [7:0] flags;
        logic uid_ok;
        logic [7:0] first;
        logic [7:0] count;
        logic [8:0] blk;
        logic [7:0] left;
        logic [1:0] bnum;
        logic [7:0] err;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic quiet;
        logic wip_mode;
        logic [`RFMB_EV_W-1:0] status;
        logic [`RFMB_EV_W-1:0] mask;
        logic [31:0] prdata;
        logic [7:0] last_err;
        logic [2:0] pin_sync;
        logic pin_seen;
    } rfmb_top_state_type;

    rfmb_top_state_type s_q, s_d;
    rfmb_crc_if crc_bus ();
    rfmb_pin_if pin_bus ();

    logic [`RFMB_EV_W-1:0] ev;
    logic [`RFMB_EV_W-1:0] w1c;
    logic [3:0] base;
    logic [9:0] last_ext;
    logic [7:0] err_v;
    logic load;
    logic hs;
    logic opt;
    logic [7:0] nb;

    // Sector index of a block number.
    function automatic logic [8:0] sector_of(input logic [9:0] b);
        return 9'(b / 10'(SECTOR_BLOCKS));
    endfunction

    // Byte k of a word, low byte first.
    function automatic logic [7:0] byte_of(input logic [63:0] w,
                                           input logic [2:0] k);
        return w[k * 8 +: 8];
    endfunction

    rfmb_crc u_crc (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus(crc_bus)
    );

    rfmb_pin u_pin (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus(pin_bus)
    );

    // Pin control is fed by frame events.
    assign pin_bus.wip_mode = s_q.wip_mode;
    assign pin_bus.rx_sof = rx_sof;
    assign pin_bus.rx_eof = rx_eof;
    assign pin_bus.rx_ok = rx_crc_ok;
    assign pin_bus.resp_sof = resp_sof;
    assign pin_bus.resp_eof = resp_eof;
    assign pin_bus.release_now = resp_none | s_q.quiet;
    assign pin_bus.wr_accept = wr_accept;
    assign pin_bus.wr_option = wr_option;

    // Open-drain pin: pulled low or released.
    assign rf_activity_pin_o = 1'b0;
    assign rf_activity_pin_oe = pin_bus.drive;

    // Request fields shared by the parser and the responder.
    assign opt = s_q.flags[`RFMB_FLAG_OPT];
    assign hs = s_q.tx_valid & tx_ready;
    assign base = s_q.flags[`RFMB_FLAG_ADDR] ? `RFMB_IDX_FIRST_ADDR
                                             : `RFMB_IDX_FIRST_SEL;
    assign last_ext = {2'b00, s_q.first} + {2'b00, s_q.count};

    // Range and protection checks.
    always_comb begin
        if (last_ext >= 10'(NUM_BLOCKS)) begin
            err_v = `RFMB_ERR_NO_BLOCK;
        end else if (sector_of({2'b00, s_q.first}) != sector_of(last_ext)) begin
            err_v = `RFMB_ERR_UNSPEC;
        end else if (sec_read_denied) begin
            err_v = `RFMB_ERR_RD_PROT;
        end else begin
            err_v = `RFMB_ERR_NONE;
        end
    end

    // Registers, request parser and reply sequencer.
    always_comb begin
        s_d = s_q;
        ev = '0;
        w1c = '0;
        load = 1'b0;
        nb = 8'h00;
        crc_bus.clr = 1'b0;
        crc_bus.en = 1'b0;
        crc_bus.data = 8'h00;
        s_d.quiet = 1'b0;
        // Pin level is followed once the second and third stages agree.
        s_d.pin_sync = {s_q.pin_sync[1:0], rf_activity_pin_i};
        if (s_q.pin_sync[2] == s_q.pin_sync[1]) begin
            s_d.pin_seen = s_q.pin_sync[2];
        end
        // Register writes take effect in the access phase.
        if (psel && penable && pwrite) begin
            if (paddr == `RFMB_REG_CTRL) begin
                s_d.wip_mode = pwdata[`RFMB_CTRL_WIP_BIT];
            end else if (paddr == `RFMB_REG_STATUS) begin
                w1c = pwdata[`RFMB_EV_W-1:0];
            end else if (paddr == `RFMB_REG_MASK) begin
                s_d.mask = pwdata[`RFMB_EV_W-1:0];
            end
        end
        // Read data is captured in the setup phase.
        if (psel && !penable) begin
            if (paddr == `RFMB_REG_CTRL) begin
                s_d.prdata = {31'h0, s_q.wip_mode};
            end else if (paddr == `RFMB_REG_STATUS) begin
                s_d.prdata = {29'h0, s_q.status};
            end else if (paddr == `RFMB_REG_MASK) begin
                s_d.prdata = {29'h0, s_q.mask};
            end else if (paddr == `RFMB_REG_INFO) begin
                s_d.prdata = {18'h0, s_q.st, s_q.pin_seen, pin_bus.drive,
                              s_q.last_err};
            end else begin
                s_d.prdata = 32'h0;
            end
        end
        case (s_q.st)
            ST_IDLE, ST_SKIP: begin
                if (rx_sof) begin
                    s_d.st = ST_RX;
                    s_d.idx = `RFMB_IDX_FLAGS;
                    s_d.uid_ok = 1'b1;
                end else if (rx_eof) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_RX: begin
                if (rx_sof) begin
                    s_d.idx = `RFMB_IDX_FLAGS;
                    s_d.uid_ok = 1'b1;
                end else if (rx_valid) begin
                    if (s_q.idx != `RFMB_IDX_MAX) begin
                        s_d.idx = s_q.idx + 4'h1;
                    end
                    if (s_q.idx == `RFMB_IDX_FLAGS) begin
                        s_d.flags = rx_data;
                    end else if (s_q.idx == `RFMB_IDX_CMD) begin
                        if (rx_data != `RFMB_CMD_READ_MULTI) begin
                            s_d.st = ST_SKIP;
                        end
                    end else if (s_q.idx < base) begin
                        if (rx_data != byte_of(own_uid,
                                3'(s_q.idx - `RFMB_IDX_UID))) begin
                            s_d.uid_ok = 1'b0;
                        end
                    end else if (s_q.idx == base) begin
                        s_d.first = rx_data;
                        s_d.blk = {1'b0, rx_data};
                    end else if (s_q.idx == base + 4'h1) begin
                        s_d.count = rx_data;
                    end
                end else if (rx_eof) begin
                    if (!rx_crc_ok || !s_q.uid_ok ||
                        s_q.idx != base + 4'h2) begin
                        s_d.st = ST_IDLE;
                        s_d.quiet = 1'b1;
                        ev[`RFMB_EV_IGNORED] = 1'b1;
                    end else begin
                        s_d.st = ST_TX;
                        s_d.err = err_v;
                        s_d.last_err = err_v;
                        s_d.left = s_q.count;
                        s_d.bnum = 2'h0;
                        s_d.ph = PH_FLAGS;
                        crc_bus.clr = 1'b1;
                        load = 1'b1;
                    end
                end
            end
            ST_TX: begin
                if (hs || s_q.ph == PH_NEXT) begin
                    s_d.tx_valid = 1'b0;
                    case (s_q.ph)
                        PH_FLAGS: begin
                            load = 1'b1;
                            if (s_q.err != `RFMB_ERR_NONE) begin
                                s_d.ph = PH_CODE;
                            end else begin
                                s_d.ph = opt ? PH_SEC : PH_DATA;
                            end
                        end
                        PH_CODE: begin
                            load = 1'b1;
                            s_d.ph = PH_CRCL;
                        end
                        PH_SEC: begin
                            load = 1'b1;
                            s_d.ph = PH_DATA;
                        end
                        PH_DATA: begin
                            if (s_q.bnum != `RFMB_LAST_BYTE) begin
                                load = 1'b1;
                                s_d.bnum = s_q.bnum + 2'h1;
                            end else if (s_q.left == 8'h00) begin
                                load = 1'b1;
                                s_d.ph = PH_CRCL;
                            end else begin
                                // One idle cycle lets the memory follow.
                                s_d.blk = s_q.blk + 9'h001;
                                s_d.left = s_q.left - 8'h01;
                                s_d.bnum = 2'h0;
                                s_d.ph = PH_NEXT;
                            end
                        end
                        PH_NEXT: begin
                            load = 1'b1;
                            s_d.ph = opt ? PH_SEC : PH_DATA;
                        end
                        PH_CRCL: begin
                            load = 1'b1;
                            s_d.ph = PH_CRCH;
                        end
                        PH_CRCH: begin
                            s_d.st = ST_IDLE;
                            s_d.ph = PH_FLAGS;
                            if (s_q.err != `RFMB_ERR_NONE) begin
                                ev[`RFMB_EV_RD_ERR] = 1'b1;
                            end else begin
                                ev[`RFMB_EV_RD_OK] = 1'b1;
                            end
                        end
                        default: begin
                            s_d.st = ST_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // Selects the next reply byte and feeds it to the CRC, except the two CRC bytes.
        if (load) begin
            case (s_d.ph)
                PH_FLAGS: nb = (s_d.err != `RFMB_ERR_NONE) ? `RFMB_RESP_ERR
                                                           : `RFMB_RESP_OK;
                PH_CODE: nb = s_d.err;
                PH_SEC: nb = {3'b000, sec_status[4:0]};
                PH_DATA: nb = byte_of({32'h0, mem_rdata}, {1'b0, s_d.bnum});
                PH_CRCL: nb = ~crc_bus.crc[7:0];
                PH_CRCH: nb = ~crc_bus.crc[15:8];
                default: nb = 8'h00;
            endcase
            s_d.tx_valid = 1'b1;
            s_d.tx_data = nb;
            s_d.tx_last = (s_d.ph == PH_CRCH);
            if (s_d.ph != PH_CRCL && s_d.ph != PH_CRCH) begin
                crc_bus.en = 1'b1;
                crc_bus.data = nb;
            end
        end
        // A new event wins over a clear in the same cycle.
        s_d.status = (s_q.status & ~w1c) | ev;
    end

    // Registers the whole block state.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.ph <= PH_FLAGS;
        end else begin
            s_q <= s_d;
        end
    end

    // Zero wait states; unmapped addresses report an error.
    assign pready = 1'b1;
    assign pslverr = psel && penable &&
        paddr != `RFMB_REG_CTRL && paddr != `RFMB_REG_STATUS &&
        paddr != `RFMB_REG_MASK && paddr != `RFMB_REG_INFO;
    assign prdata = s_q.prdata;
    assign irq = |(s_q.status & s_q.mask);
    assign mem_addr = s_q.blk;
    assign tx_valid = s_q.tx_valid;
    assign tx_data = s_q.tx_data;
    assign tx_last = s_q.tx_last;
endmodule

// ===== tb/rfmb_mem_model.sv
// Memory and sector security model facing the read handler.
module rfmb_mem_model (
    input wire logic [8:0] mem_addr,
    input wire logic deny,
    output logic [31:0] mem_rdata,
    output logic [7:0] sec_status,
    output logic sec_read_denied
);
    timeunit 1ns;
    timeprecision 100ps;
    // Answers at once; reserved security bits are set for the handler.
    always_comb begin
        mem_rdata = {mem_addr[7:0], ~mem_addr[7:0], 8'h3c, mem_addr[7:0]};
        sec_status = {3'h7, 2'h1, mem_addr[7:5]};
        sec_read_denied = deny;
    end
endmodule

// ===== tb/rfmb_top_sva.sv
// Checker for the activity pin and the reply byte stream.
module rfmb_top_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic rx_sof,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic resp_sof,
    input wire logic resp_eof,
    input wire logic wr_accept,
    input wire logic wr_option,
    input wire logic rf_activity_pin_o,
    input wire logic rf_activity_pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic md_q;
    logic opt_q;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Mirrors the pin mode and the last write's option flag.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            md_q <= 1'b0;
            opt_q <= 1'b0;
        end else begin
            if (psel && penable && pwrite && paddr == 12'h000) begin
                md_q <= pwdata[0];
            end
            if (wr_accept) begin
                opt_q <= wr_option;
            end
        end
    end
    sequence s_held;
        tx_valid && !tx_ready;
    endsequence
    a_busy_sof_drive: assert property (
        !md_q && rx_sof |=> rf_activity_pin_oe) else $error("pin late");
    a_busy_eof_free: assert property (
        !md_q && resp_eof |=> !rf_activity_pin_oe) else $error("pin held");
    a_busy_idle_free: assert property (
        !md_q && !rf_activity_pin_oe && !rx_sof |=> !rf_activity_pin_oe)
        else $error("pin driven idle");
    a_wip_accept_drive: assert property (
        md_q && wr_accept |=> rf_activity_pin_oe) else $error("no wip");
    a_wip_sof_free: assert property (
        md_q && resp_sof && !opt_q |=> !rf_activity_pin_oe)
        else $error("wip held");
    a_wip_opt_hold: assert property (
        md_q && rf_activity_pin_oe && resp_sof && opt_q
        |=> rf_activity_pin_oe) else $error("wip dropped");
    a_wip_read_free: assert property (
        md_q && !rf_activity_pin_oe && !wr_accept |=> !rf_activity_pin_oe)
        else $error("wip without write");
    a_pin_low_only: assert property (
        !rf_activity_pin_o) else $error("pin driven high");
    a_byte_stands: assert property (
        s_held |=> tx_valid && $stable(tx_data)) else $error("byte lost");
endmodule
bind rfmb_top rfmb_top_sva chk_u (.clk(clk), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .rx_sof(rx_sof), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .resp_sof(resp_sof),
    .resp_eof(resp_eof), .wr_accept(wr_accept), .wr_option(wr_option),
    .rf_activity_pin_o(rf_activity_pin_o),
    .rf_activity_pin_oe(rf_activity_pin_oe));

// ===== tb/test_rf_multiblock_read_and_activity_pin.sv
// Self-checking bench for the multi-block read handler and activity pin.
module test_rf_multiblock_read_and_activity_pin;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] UID = 64'h0011_2233_4455_6677; // Arbitrary.
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, md = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd, mdat;
    logic pready, pslverr, perr, irq, tx_valid, tx_last, pin_o, oe, sdn;
    logic rx_sof = 1'b0, rx_valid = 1'b0, rx_eof = 1'b0, tx_ready = 1'b0;
    logic resp_sof = 1'b0, resp_eof = 1'b0, wr_acc = 1'b0, wr_opt = 1'b0;
    logic deny = 1'b0;
    logic [7:0] rx_data = 8'h00, tx_data, sec;
    logic [8:0] maddr;
    logic [7:0] got[$], ex[$], fr[$];
    int errors = 0;
    int checks_done = 0;
    always #12.5 clk = ~clk;
    rfmb_top #(.NUM_BLOCKS(128), .SECTOR_BLOCKS(32)) dut_u (.clk(clk),
        .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .rx_sof(rx_sof), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_eof(rx_eof), .rx_crc_ok(1'b1),
        .own_uid(UID), .mem_addr(maddr), .mem_rdata(mdat),
        .sec_status(sec), .sec_read_denied(sdn), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .resp_sof(resp_sof), .resp_eof(resp_eof), .resp_none(1'b0),
        .wr_accept(wr_acc), .wr_option(wr_opt), .rf_activity_pin_i(!oe),
        .rf_activity_pin_o(pin_o), .rf_activity_pin_oe(oe));
    rfmb_mem_model mem_u (.mem_addr(maddr), .deny(deny),
        .mem_rdata(mdat), .sec_status(sec), .sec_read_denied(sdn));
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One APB transfer, held until pready is seen high.
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        perr = pslverr;
        if (n >= 50) begin
            errors++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [15:0] crc16(logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return ~c;
    endfunction
    // Sends the bytes in fr as one frame.
    task automatic frm();
        @(posedge clk);
        rx_sof <= 1'b1;
        foreach (fr[i]) begin
            @(posedge clk);
            rx_sof <= 1'b0;
            rx_valid <= 1'b1;
            rx_data <= fr[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_eof <= 1'b1;
        @(posedge clk);
        rx_eof <= 1'b0;
    endtask
    // Plays the transmitter and checks the pin around the reply.
    task automatic reply(string n, logic b, logic m, logic s);
        int k = 0;
        got.delete();
        @(negedge clk);
        chk({n, " pin"}, oe, m);
        @(posedge clk);
        resp_sof <= 1'b1;
        @(posedge clk);
        resp_sof <= 1'b0;
        while (b && k < 3000) begin
            @(posedge clk);
            k++;
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                got.push_back(tx_data);
                if (tx_last === 1'b1) break;
            end
            tx_ready <= k[0];
        end
        @(negedge clk);
        chk({n, " pin sof"}, oe, s);
        @(posedge clk);
        tx_ready <= 1'b0;
        resp_eof <= 1'b1;
        @(posedge clk);
        resp_eof <= 1'b0;
        @(negedge clk);
        chk({n, " pin end"}, oe, 1'b0);
        if (k >= 3000) begin
            errors++;
            test_done();
        end
        chk({n, " len"}, got.size(), ex.size());
        foreach (ex[i]) chk(n, got[i], ex[i]);
        $display("test %s done", n);
    endtask
    // Read request; e is the expected error code, zero for data.
    task automatic rdm(logic [7:0] fl, f, c, e);
        logic [15:0] r;
        fr = {fl, 8'h23};
        if (fl[5]) for (int k = 0; k < 8; k++) fr.push_back(UID[8*k +: 8]);
        fr.push_back(f);
        fr.push_back(c);
        frm();
        ex = {8'h01, e};
        if (e == 8'h00) begin
            ex = {8'h00};
            for (int b = f; b <= f + c; b++) begin
                if (fl[6]) ex.push_back({5'h01, b[7:5]});
                ex.push_back(b[7:0]);
                ex.push_back(8'h3c);
                ex.push_back(~b[7:0]);
                ex.push_back(b[7:0]);
            end
        end
        r = crc16(ex);
        ex.push_back(r[7:0]);
        ex.push_back(r[15:8]);
        reply("read", 1'b1, !md, !md);
    endtask
    // Write request, accepted or refused.
    task automatic wr(logic a, logic o);
        fr = {8'h02, 8'h21, 8'h05, 8'h11, 8'h22, 8'h33, 8'h44};
        frm();
        wr_acc <= a;
        wr_opt <= o;
        @(posedge clk);
        wr_acc <= 1'b0;
        repeat (4) @(posedge clk);
        ex.delete();
        reply("write", 1'b0, !md || a, !md || (a && o));
    endtask
    // Registers, then reads and writes in both pin modes.
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {perr, rd[30:0]}, 32'h80000000);
        rdm(8'h42, 8'h05, 8'h02, 8'h00);
        rdm(8'h22, 8'h40, 8'h06, 8'h00);
        rdm(8'h02, 8'h20, 8'h1f, 8'h00);
        rdm(8'h02, 8'h1e, 8'h02, 8'h0f);
        rdm(8'h02, 8'h80, 8'h00, 8'h10);
        deny <= 1'b1;
        rdm(8'h02, 8'h08, 8'h00, 8'h15);
        deny <= 1'b0;
        apb(1'b1, 12'h008, 32'h2);
        @(negedge clk);
        chk("irq on", irq, 1'b1);
        apb(1'b1, 12'h004, 32'h2);
        @(negedge clk);
        chk("irq off", irq, 1'b0);
        wr(1'b0, 1'b0);
        wr(1'b1, 1'b0);
        wr(1'b1, 1'b1);
        apb(1'b1, 12'h000, 32'h1);
        md = 1'b1;
        rdm(8'h42, 8'h05, 8'h02, 8'h00);
        wr(1'b0, 1'b0);
        wr(1'b1, 1'b0);
        wr(1'b1, 1'b1);
        test_done();
    end
endmodule
